/* src/dd2_pkg.sv */
// Shared constants for the DDR2 command and burst link
`default_nettype none
package dd2_pkg;
  localparam int ROW_W = 13;
  localparam int BA_W  = 2;
  localparam int DQ_W  = 16;
  localparam int COL_W = 10;
  // Command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRW   = 4'h0;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_STOP  = 4'h6;
  localparam logic [3:0] CMD_NOP   = 4'h7;
  // Mode register selects on the bank pins
  localparam logic [1:0] MR_BASE = 2'h0;
  localparam logic [1:0] MR_EXT1 = 2'h1;
  // Base mode register fields
  localparam int         BL_LSB   = 0;
  localparam logic [2:0] BL_FOUR  = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  localparam int         BT_BIT   = 3;
  localparam int         CL_LSB   = 4;
  localparam logic [2:0] CL_RST   = 3'h3;
  // Extended mode register fields
  localparam int         AL_LSB   = 3;
  localparam logic [2:0] AL_MAX   = 3'h5;
  localparam int         RTT_HI   = 6;
  localparam int         RTT_LO   = 2;
  localparam logic [1:0] RTT_OFF  = 2'h0;
  localparam int         STB_DIS  = 10;
  // Burst lengths in words
  localparam logic [3:0] BEATS_FOUR  = 4'h4;
  localparam logic [3:0] BEATS_EIGHT = 4'h8;
  // Controller register word indices
  localparam logic [2:0] REG_CMD    = 3'h0;
  localparam logic [2:0] REG_ADDR   = 3'h1;
  localparam logic [2:0] REG_MODE   = 3'h2;
  localparam logic [2:0] REG_WDATA  = 3'h3;
  localparam logic [2:0] REG_RDATA  = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  // Register fields
  localparam int GO_BIT = 0;
  localparam int WR_BIT = 1;
  localparam int MR_BIT = 2;
  localparam int ODT_BIT = 3;
  localparam int ROW_LSB = 10;
  localparam int BA_LSB = 23;
  localparam int MR_SEL_LSB = 16;
endpackage
`default_nettype wire

/* src/dd2_link_if.sv */
// Link between the memory controller and the memory device
`timescale 1ns/100ps
`default_nettype none
interface dd2_link_if;
  logic                       ck;
  logic [3:0]                 cmd_n;
  logic [dd2_pkg::BA_W-1:0]   ba;
  logic [dd2_pkg::ROW_W-1:0]  addr;
  logic                       odt;
  logic [1:0]                 write_mask;
  logic [dd2_pkg::DQ_W-1:0]   ctl_dq_o;
  logic                       ctl_dq_oe_n;
  logic [1:0]                 ctl_strobe_o;
  logic                       ctl_strobe_oe_n;
  logic [dd2_pkg::DQ_W-1:0]   dev_dq_o;
  logic                       dev_dq_oe_n;
  logic [1:0]                 dev_strobe_o;
  logic                       dev_strobe_oe_n;
  logic [1:0]                 dev_strobe_n_o;
  logic                       dev_strobe_n_oe_n;
  logic [dd2_pkg::DQ_W-1:0]   dq;
  logic [1:0]                 byte_strobe;
  logic [1:0]                 byte_strobe_n;
  // Wire levels; an undriven wire reads low
  assign dq = !dev_dq_oe_n ? dev_dq_o : (!ctl_dq_oe_n ? ctl_dq_o : '0);
  assign byte_strobe = !dev_strobe_oe_n ? dev_strobe_o
                     : (!ctl_strobe_oe_n ? ctl_strobe_o : 2'h0);
  assign byte_strobe_n = !dev_strobe_n_oe_n ? dev_strobe_n_o : 2'h0;
  modport ctl (output ck, cmd_n, ba, addr, odt, write_mask, ctl_dq_o, ctl_dq_oe_n,
               ctl_strobe_o, ctl_strobe_oe_n, input dq, byte_strobe);
  modport dev (input ck, cmd_n, ba, addr, odt, write_mask, dq, byte_strobe,
               output dev_dq_o, dev_dq_oe_n, dev_strobe_o, dev_strobe_oe_n,
               dev_strobe_n_o, dev_strobe_n_oe_n);
endinterface
`default_nettype wire

/* src/dd2_burst_order.sv */
// Word position of a burst beat for sequential or interleaved order
`timescale 1ns/100ps
`default_nettype none
module dd2_burst_order
(
  // Start column and beat count
  input  wire logic [2:0] start,
  input  wire logic [2:0] count,
  input  wire logic       interleave,
  // Word position inside the aligned block
  output logic [2:0]      pos
);
  always_comb
  begin
    if (interleave)
      pos = start ^ count;
    else
      pos = {start[2] ^ count[2], 2'(start[1:0] + count[1:0])};
  end
endmodule
`default_nettype wire

/* src/dd2_dev.sv */
// DDR2 memory device end: command decode, latencies, bursts, termination
//
// Behaviour
// - Termination follows the termination control pin
// - Termination forced off during self refresh
// - Two mode bits select termination value
// - Activate: cs and ras low, others high
// - Column command accepted clock after activate
// - Controller waits out activate delay beyond additive latency
// - Controller precharges and spaces activates properly
// - Column command: we high read, low write
// - Column command held additive latency before issue
// - Read latency additive plus column; write one less
// - Burst length four or eight only
// - Mode bit three picks burst order
// - Nibble-wrapping sequential, xor interleaved ordering
// - Bursts wrap inside their aligned block
// - Controller never interrupts bursts; seamless allowed, but the device takes column commands only when idle
// - Burst stop code does nothing
// - First read word after read latency clocks
// - Strobe preamble low, words on strobe edges
// - Column from base, additive from extended register
// - Strobe single-ended or differential by mode bit
`timescale 1ns/100ps
`default_nettype none
module dd2_dev
(
  // Link to the controller
  dd2_link_if.dev link,
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Power state
  input  wire logic self_refresh,
  // Status
  output logic       term_on,
  output logic [1:0] term_sel,
  output logic       array_issue,
  output logic       strobe_diff
);
  localparam int WORDS = 32;

  typedef struct packed {
    logic                      ck;
    logic [3:0]                cmd_n;
    logic [dd2_pkg::BA_W-1:0]  ba;
    logic [dd2_pkg::ROW_W-1:0] addr;
    logic                      odt;
    logic                      stb;
    logic [dd2_pkg::DQ_W-1:0]  dq;
    logic [1:0]                mask;
  } dd2_pins_type;

  typedef enum logic [3:0] {
    D_IDLE   = 4'h1,
    D_RWAIT  = 4'h2,
    D_RBURST = 4'h4,
    D_WBURST = 4'h8
  } dd2_dev_state_type;

  typedef struct packed {
    dd2_pins_type                        s1;
    dd2_pins_type                        s2;
    logic                                ck_p;
    logic                                stb_p;
    logic                                bl8;
    logic                                ilv;
    logic [2:0]                          cl;
    logic [2:0]                          al;
    logic [1:0]                          rtt;
    logic                                diff;
    dd2_dev_state_type                   st;
    logic                                posted;
    logic [3:0]                          cnt;
    logic [1:0]                          bank;
    logic [2:0]                          col;
    logic [3:0]                          beat;
    logic [dd2_pkg::DQ_W-1:0]            dq_o;
    logic                                dq_oe_n;
    logic                                stb_o;
    logic                                stb_oe_n;
    logic                                issue;
    logic                                term_on;
    logic [1:0]                          term_sel;
    logic [WORDS-1:0][dd2_pkg::DQ_W-1:0] mem;
  } dd2_dev_reg_type;

  localparam dd2_dev_reg_type RST_VAL = '{
    cl:       dd2_pkg::CL_RST,
    st:       D_IDLE,
    dq_oe_n:  1'b1,
    stb_oe_n: 1'b1,
    default:  '0
  };

  dd2_dev_reg_type q;
  dd2_dev_reg_type d;
  logic            rise;
  logic            ck_edge;
  logic            stb_edge;
  logic [3:0]      rl;
  logic [3:0]      wl;
  logic [3:0]      blen;
  logic [3:0]      cnt_n;
  logic [2:0]      pos;
  logic [4:0]      idx;

  ////////////////////////////////////////////////////////////////////////
  // Derived values
  assign rise     = q.s2.ck & ~q.ck_p;
  assign ck_edge  = q.s2.ck ^ q.ck_p;
  assign stb_edge = q.s2.stb ^ q.stb_p;
  assign rl       = {1'b0, q.al} + {1'b0, q.cl};
  assign wl       = rl - 4'h1;
  assign blen     = q.bl8 ? dd2_pkg::BEATS_EIGHT : dd2_pkg::BEATS_FOUR;
  assign cnt_n    = q.cnt + 4'h1;
  assign idx      = {q.bank, pos};

  dd2_burst_order u_order
  (
    .start      (q.col),
    .count      (q.beat[2:0]),
    .interleave (q.ilv),
    .pos        (pos)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d = q;
    d.s1 = '{link.ck, link.cmd_n, link.ba, link.addr, link.odt,
             link.byte_strobe[0], link.dq, link.write_mask};
    d.s2 = q.s1;
    d.ck_p = q.s2.ck;
    d.stb_p = q.s2.stb;
    d.issue = 1'b0;
    // Termination gated by pin, power state and selected value
    d.term_on = q.s2.odt & ~self_refresh & (q.rtt != dd2_pkg::RTT_OFF);
    d.term_sel = q.rtt;
    // Rises counted from the column command; array access after additive latency
    if (rise && q.st != D_IDLE)
    begin
      d.cnt = cnt_n;
      if (q.posted && cnt_n == {1'b0, q.al})
      begin
        d.issue = 1'b1;
        d.posted = 1'b0;
      end
    end
    unique case (q.st)
      D_IDLE:
      begin
        if (rise)
        begin
          case (q.s2.cmd_n)
            dd2_pkg::CMD_MRW:
            begin
              if (q.s2.ba == dd2_pkg::MR_BASE)
              begin
                if (q.s2.addr[dd2_pkg::BL_LSB +: 3] == dd2_pkg::BL_FOUR)
                  d.bl8 = 1'b0;
                else if (q.s2.addr[dd2_pkg::BL_LSB +: 3] == dd2_pkg::BL_EIGHT)
                  d.bl8 = 1'b1;
                d.ilv = q.s2.addr[dd2_pkg::BT_BIT];
                d.cl = q.s2.addr[dd2_pkg::CL_LSB +: 3];
              end
              else if (q.s2.ba == dd2_pkg::MR_EXT1)
              begin
                if (q.s2.addr[dd2_pkg::AL_LSB +: 3] <= dd2_pkg::AL_MAX)
                  d.al = q.s2.addr[dd2_pkg::AL_LSB +: 3];
                d.rtt = {q.s2.addr[dd2_pkg::RTT_HI], q.s2.addr[dd2_pkg::RTT_LO]};
                d.diff = ~q.s2.addr[dd2_pkg::STB_DIS];
              end
            end
            dd2_pkg::CMD_READ, dd2_pkg::CMD_WRITE:
            begin
              // Taken at once, even on the clock right after an activate
              d.bank = q.s2.ba;
              d.col = q.s2.addr[2:0];
              d.cnt = 4'h0;
              d.beat = 4'h0;
              d.posted = (q.al != 3'h0);
              d.issue = (q.al == 3'h0);
              d.st = (q.s2.cmd_n == dd2_pkg::CMD_WRITE) ? D_WBURST : D_RWAIT;
            end
            dd2_pkg::CMD_STOP:
              d.st = D_IDLE;
            default:
              // Activate only opens a row; nothing to hold here
              d.st = D_IDLE;
          endcase
        end
      end
      D_RWAIT:
      begin
        if (rise && cnt_n == rl - 4'h1)
        begin
          d.stb_oe_n = 1'b0;
          d.stb_o = 1'b0;
        end
        if (rise && cnt_n == rl)
        begin
          d.dq_o = q.mem[idx];
          d.dq_oe_n = 1'b0;
          d.stb_o = 1'b1;
          d.beat = 4'h1;
          d.st = D_RBURST;
        end
      end
      D_RBURST:
      begin
        if (ck_edge)
        begin
          if (q.beat == blen)
          begin
            d.dq_oe_n = 1'b1;
            d.stb_oe_n = 1'b1;
            d.stb_o = 1'b0;
            d.st = D_IDLE;
          end
          else
          begin
            d.dq_o = q.mem[idx];
            d.stb_o = ~q.stb_o;
            d.beat = q.beat + 4'h1;
          end
        end
      end
      D_WBURST:
      begin
        // Words land on strobe edges from the write latency rise on
        if (stb_edge && cnt_n >= wl)
        begin
          if (!q.s2.mask[0])
            d.mem[idx][7:0] = q.s2.dq[7:0];
          if (!q.s2.mask[1])
            d.mem[idx][15:8] = q.s2.dq[15:8];
          d.beat = q.beat + 4'h1;
          if (q.beat + 4'h1 == blen)
            d.st = D_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= RST_VAL;
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.dev_dq_o          = q.dq_o;
  assign link.dev_dq_oe_n       = q.dq_oe_n;
  assign link.dev_strobe_o      = {2{q.stb_o}};
  assign link.dev_strobe_oe_n   = q.stb_oe_n;
  assign link.dev_strobe_n_o    = {2{~q.stb_o}};
  assign link.dev_strobe_n_oe_n = q.stb_oe_n | ~q.diff;
  assign term_on                = q.term_on;
  assign term_sel               = q.term_sel;
  assign array_issue            = q.issue;
  assign strobe_diff            = q.diff;
endmodule
`default_nettype wire

/* src/dd2_ctl.sv */
// DDR2 memory controller end with an Avalon-MM register port
`timescale 1ns/100ps
`default_nettype none
module dd2_ctl
#(
  parameter logic [3:0] CK_HALF  = 4'h6,
  parameter logic [2:0] T_RCD_CK = 3'h3,
  parameter logic [2:0] T_RP_CK  = 3'h3,
  parameter logic [2:0] T_MRD_CK = 3'h2
)
(
  // Link to the device
  dd2_link_if.ctl link,
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  typedef enum logic [2:0] {
    C_IDLE  = 3'h1,
    C_RDATA = 3'h2,
    C_WDATA = 3'h4
  } dd2_ctl_state_type;

  typedef struct packed {
    logic                       ck;
    logic [3:0]                 div;
    dd2_ctl_state_type          st;
    logic                       go;
    logic                       wr;
    logic                       mrw;
    logic                       odt;
    logic [24:0]                acc;
    logic [17:0]                mode;
    logic [31:0]                wdata;
    logic [31:0]                rdata;
    logic                       ack;
    logic [31:0]                rdq;
    logic [3:0]                 open;
    logic [3:0][12:0]           open_row;
    logic [2:0]                 al;
    logic [2:0]                 cl;
    logic                       bl8;
    logic [2:0]                 hold;
    logic [3:0]                 cmd;
    logic [1:0]                 ba;
    logic [12:0]                addr;
    logic [3:0]                 wcnt;
    logic [3:0]                 beat;
    logic [15:0]                dq;
    logic                       dq_oe_n;
    logic                       stb;
    logic                       stb_oe_n;
    logic [16:0]                s1;
    logic [16:0]                s2;
    logic                       stb_p;
  } dd2_ctl_reg_type;

  localparam dd2_ctl_reg_type RST_VAL = '{
    st: C_IDLE, cl: dd2_pkg::CL_RST, cmd: dd2_pkg::CMD_NOP,
    dq_oe_n: 1'b1, stb_oe_n: 1'b1, default: '0
  };

  dd2_ctl_reg_type q;
  dd2_ctl_reg_type d;
  logic            tick;
  logic            rise;
  logic            fall;
  logic            busy;
  logic            req;
  logic [1:0]      b;
  logic [12:0]     row;
  logic [3:0]      wl;
  logic [3:0]      blen;

  assign tick = (q.div == CK_HALF - 4'h1);
  assign rise = tick & ~q.ck;
  assign fall = tick & q.ck;
  assign busy = q.go | q.mrw | (q.st != C_IDLE);
  assign req  = avs_read | avs_write;
  assign b    = q.acc[dd2_pkg::BA_LSB +: 2];
  assign row  = q.acc[dd2_pkg::ROW_LSB +: 13];
  assign wl   = {1'b0, q.al} + {1'b0, q.cl} - 4'h1;
  assign blen = q.bl8 ? dd2_pkg::BEATS_EIGHT : dd2_pkg::BEATS_FOUR;

  always_comb
  begin
    d = q;
    d.div = tick ? 4'h0 : q.div + 4'h1;
    d.ck = q.ck ^ tick;
    d.s1 = {link.byte_strobe[0], link.dq};
    d.s2 = q.s1;
    d.stb_p = q.s2[16];
    ////////////////////////////////////////////////////////////////////////
    // Register port: one wait cycle, write lands with waitrequest low
    d.ack = req & ~q.ack;
    if (req && !q.ack)
    begin
      unique case (avs_address)
        dd2_pkg::REG_CMD:    d.rdq = {28'h000_0000, q.odt, 3'h0};
        dd2_pkg::REG_ADDR:   d.rdq = {7'h00, q.acc};
        dd2_pkg::REG_MODE:   d.rdq = {14'h0000, q.mode};
        dd2_pkg::REG_WDATA:  d.rdq = q.wdata;
        dd2_pkg::REG_RDATA:  d.rdq = q.rdata;
        dd2_pkg::REG_STATUS: d.rdq = {27'h000_0000, q.open, busy};
        default:             d.rdq = 32'h0000_0000;
      endcase
    end
    if (avs_write && q.ack)
    begin
      case (avs_address)
        dd2_pkg::REG_CMD:
        begin
          d.odt = avs_writedata[dd2_pkg::ODT_BIT];
          if (!busy)
          begin
            d.go = avs_writedata[dd2_pkg::GO_BIT];
            d.wr = avs_writedata[dd2_pkg::WR_BIT];
            d.mrw = avs_writedata[dd2_pkg::MR_BIT];
          end
        end
        dd2_pkg::REG_ADDR:  d.acc = busy ? q.acc : avs_writedata[24:0];
        dd2_pkg::REG_MODE:  d.mode = busy ? q.mode : avs_writedata[17:0];
        dd2_pkg::REG_WDATA: d.wdata = avs_writedata;
        default:            d.odt = q.odt;
      endcase
    end
    ////////////////////////////////////////////////////////////////////////
    // Commands change on the falling link clock edge
    if (fall)
    begin
      d.cmd = dd2_pkg::CMD_NOP;
      if (q.hold != 3'h0)
        d.hold = q.hold - 3'h1;
      else if (q.st == C_IDLE && q.mrw)
      begin
        d.cmd = dd2_pkg::CMD_MRW;
        d.ba = q.mode[dd2_pkg::MR_SEL_LSB +: 2];
        d.addr = q.mode[12:0];
        if (q.mode[dd2_pkg::MR_SEL_LSB +: 2] == dd2_pkg::MR_BASE)
        begin
          d.bl8 = (q.mode[dd2_pkg::BL_LSB +: 3] == dd2_pkg::BL_EIGHT);
          d.cl = q.mode[dd2_pkg::CL_LSB +: 3];
        end
        else if (q.mode[dd2_pkg::MR_SEL_LSB +: 2] == dd2_pkg::MR_EXT1)
          d.al = q.mode[dd2_pkg::AL_LSB +: 3];
        d.mrw = 1'b0;
        d.hold = T_MRD_CK;
      end
      else if (q.st == C_IDLE && q.go)
      begin
        d.ba = b;
        if (q.open[b] && q.open_row[b] == row)
        begin
          d.cmd = q.wr ? dd2_pkg::CMD_WRITE : dd2_pkg::CMD_READ;
          d.addr = {3'h0, q.acc[dd2_pkg::COL_W-1:0]};
          d.go = 1'b0;
          d.wcnt = 4'h0;
          d.beat = 4'h0;
          d.st = q.wr ? C_WDATA : C_RDATA;
        end
        else if (q.open[b])
        begin
          d.cmd = dd2_pkg::CMD_PRE;
          d.addr = 13'h0000;
          d.open[b] = 1'b0;
          d.hold = T_RP_CK;
        end
        else
        begin
          d.cmd = dd2_pkg::CMD_ACT;
          d.addr = row;
          d.open[b] = 1'b1;
          d.open_row[b] = row;
          // Column may follow next clock once additive latency covers the delay
          d.hold = (T_RCD_CK > q.al) ? T_RCD_CK - q.al : 3'h0;
        end
      end
    end
    ////////////////////////////////////////////////////////////////////////
    // Write burst: preamble a clock before write latency, then words on edges
    if (q.st == C_WDATA && tick)
    begin
      if (q.beat != 4'h0)
      begin
        if (q.beat == blen)
        begin
          d.dq_oe_n = 1'b1;
          d.stb_oe_n = 1'b1;
          d.stb = 1'b0;
          d.st = C_IDLE;
        end
        else
        begin
          d.dq = q.beat[0] ? q.wdata[31:16] : q.wdata[15:0];
          d.stb = ~q.stb;
          d.beat = q.beat + 4'h1;
        end
      end
      else if (rise)
      begin
        d.wcnt = q.wcnt + 4'h1;
        if (q.wcnt == wl - 4'h1)
        begin
          d.stb_oe_n = 1'b0;
          d.stb = 1'b0;
          d.dq_oe_n = 1'b0;
        end
        if (q.wcnt == wl)
        begin
          d.dq = q.wdata[15:0];
          d.stb = 1'b1;
          d.beat = 4'h1;
        end
      end
    end
    // Read burst captured on the device strobe edges
    if (q.st == C_RDATA && (q.s2[16] ^ q.stb_p))
    begin
      if (q.beat == 4'h0)
        d.rdata[15:0] = q.s2[15:0];
      if (q.beat == 4'h1)
        d.rdata[31:16] = q.s2[15:0];
      d.beat = q.beat + 4'h1;
      if (q.beat + 4'h1 == blen)
        d.st = C_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= RST_VAL;
    else
      q <= d;
  end

  assign avs_waitrequest      = req & ~q.ack;
  assign avs_readdata         = q.rdq;
  assign link.ck              = q.ck;
  assign link.cmd_n           = q.cmd;
  assign link.ba              = q.ba;
  assign link.addr            = q.addr;
  assign link.odt             = q.odt;
  assign link.write_mask      = 2'h0;
  assign link.ctl_dq_o        = q.dq;
  assign link.ctl_dq_oe_n     = q.dq_oe_n;
  assign link.ctl_strobe_o    = {2{q.stb}};
  assign link.ctl_strobe_oe_n = q.stb_oe_n;
endmodule
`default_nettype wire

/* tb/dd2_link_props.sv */
// Timing checks on the link between controller and device
`timescale 1ns/100ps
`default_nettype none
module dd2_link_props
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Link signals
  input wire logic       ck,
  input wire logic [3:0] cmd_n,
  input wire logic       ctl_dq_oe_n,
  input wire logic       dev_dq_oe_n,
  input wire logic       ctl_strobe_oe_n,
  input wire logic       dev_strobe_oe_n,
  input wire logic [1:0] byte_strobe,
  input wire logic [1:0] byte_strobe_n,
  input wire logic       dev_strobe_n_oe_n
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  a_one_dq_driver: assert property (!(!ctl_dq_oe_n && !dev_dq_oe_n))
    else $error("both ends drive dq");
  a_strobe_turn: assert property (!dev_strobe_oe_n |-> ctl_strobe_oe_n)
    else $error("both ends drive the strobe");
  a_no_stop_code: assert property (cmd_n != dd2_pkg::CMD_STOP)
    else $error("burst stop code sent");
  a_cmd_held: assert property ($rose(ck) |-> $stable(cmd_n) [*4])
    else $error("command moved at link clock rise");
  a_ck_half: assert property ($rose(ck) |-> ck [*6] ##1 !ck)
    else $error("link clock half period wrong");
  a_read_pre: assert property ($fell(dev_strobe_oe_n) |-> (byte_strobe == 2'h0) [*8])
    else $error("read preamble not low");
  a_write_pre: assert property ($fell(ctl_strobe_oe_n) |-> (byte_strobe == 2'h0) [*8])
    else $error("write preamble not low");
  a_read_lat: assert property ($rose(ck) && cmd_n == dd2_pkg::CMD_READ
    |-> ##[20:150] $fell(dev_strobe_oe_n))
    else $error("read data never started");
  a_write_lat: assert property ($rose(ck) && cmd_n == dd2_pkg::CMD_WRITE
    |-> ##[8:150] $fell(ctl_strobe_oe_n))
    else $error("write data never started");
  a_strobe_pair: assert property (!dev_strobe_n_oe_n |->
    !dev_strobe_oe_n && byte_strobe_n == ~byte_strobe)
    else $error("complement strobe not inverted");
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Bench for the DDR2 controller and device pair
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        core_clk;
  logic        rst_n;
  logic        self_refresh;
  logic [2:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        term_on;
  logic [1:0]  term_sel;
  logic        strobe_diff;
  logic [31:0] rd;
  logic [31:0] lfsr = 32'h394b;
  logic [15:0] mem [32];
  int          error_cnt = 0;
  int          checked = 0;
  logic        array_issue;
  int          issues = 0;
  dd2_link_if i_dd2_link_if ();
  dd2_ctl i_dd2_ctl (.link(i_dd2_link_if), .core_clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  dd2_dev i_dd2_dev (.link(i_dd2_link_if), .core_clk, .rst_n, .self_refresh, .term_on,
    .term_sel, .array_issue, .strobe_diff);
  dd2_link_props i_dd2_link_props
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ck(i_dd2_link_if.ck),
    .cmd_n(i_dd2_link_if.cmd_n),
    .ctl_dq_oe_n(i_dd2_link_if.ctl_dq_oe_n),
    .dev_dq_oe_n(i_dd2_link_if.dev_dq_oe_n),
    .ctl_strobe_oe_n(i_dd2_link_if.ctl_strobe_oe_n),
    .dev_strobe_oe_n(i_dd2_link_if.dev_strobe_oe_n),
    .byte_strobe(i_dd2_link_if.byte_strobe),
    .byte_strobe_n(i_dd2_link_if.byte_strobe_n),
    .dev_strobe_n_oe_n(i_dd2_link_if.dev_strobe_n_oe_n)
  );
  ////////////////////////////////////////
  initial
  begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // Counts array accesses, one per column command
  always @(posedge core_clk)
    if (array_issue === 1'b1)
      issues <= issues + 1;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Word position of beat k for start s
  function automatic int pos(input int s, input int k, input int b8, input int il);
    int hi;
    int lo;
    hi = b8 ? ((s ^ k) & 4) : (s & 4);
    lo = il ? ((s ^ k) & 3) : ((s + k) & 3);
    return hi | lo;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    logic w;
    w = 1;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // Values read right after the edge are those the slave saw at it
    for (int i = 0; i < 50 && w; i++)
    begin
      @(posedge core_clk);
      w = avs_waitrequest;
      rd = avs_readdata;
    end
    avs_read <= 0;
    avs_write <= 0;
    if (w)
    begin
      error_cnt++;
      stop_test();
    end
  endtask
  // Write a register, then a command, then wait for idle
  task automatic go(input logic [2:0] a, input int d, input int c);
    bus(1, a, d);
    bus(1, dd2_pkg::REG_CMD, c);
    for (int i = 0; i < 400; i++)
    begin
      bus(0, dd2_pkg::REG_STATUS, 0);
      if (rd[0] === 1'b0)
        return;
    end
    error_cnt++;
    stop_test();
  endtask
  ////////////////////////////////////////
  initial
  begin
    int b8, il, al, cl, rt, s, s2, bk, sd, od;
    logic [31:0] wd;
    rst_n = 0;
    self_refresh = 0;
    avs_address = 0;
    avs_read = 0;
    avs_write = 0;
    avs_writedata = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    bus(1, 3'h7, 32'h1234_5678);
    bus(0, 3'h7, 0);
    chk("unmapped", rd, 0);
    chk("strobe_diff", strobe_diff, 0);
    for (int t = 0; t < 8; t++)
    begin
      lfsr = nxt(lfsr);
      wd = nxt(lfsr);
      b8 = t & 1;
      il = (t >> 1) & 1;
      al = t % 6;
      cl = 3 + (t >> 2);
      rt = 1 + lfsr[1:0] % 3;
      sd = lfsr[4];
      od = lfsr[5];
      bk = lfsr[8:7];
      s = lfsr[11:9];
      s2 = s ^ lfsr[13:12];
      self_refresh <= lfsr[6];
      go(dd2_pkg::REG_MODE, (b8 ? 3 : 2) | il << 3 | cl << 4, od << 3 | 4);
      go(dd2_pkg::REG_MODE, 1 << 16 | al << 3 | (rt >> 1) << 6 | (rt & 1) << 2 | sd << 10,
        od << 3 | 4);
      bus(1, dd2_pkg::REG_WDATA, wd);
      go(dd2_pkg::REG_ADDR, bk << 23 | lfsr[22:10] << 10 | s, od << 3 | 3);
      for (int k = 0; k < (b8 ? 8 : 4); k++)
        mem[bk * 8 + pos(s, k, b8, il)] = k % 2 ? wd[31:16] : wd[15:0];
      go(dd2_pkg::REG_ADDR, bk << 23 | s2, od << 3 | 1);
      chk("open_bank", rd[bk + 1], 1);
      chk("array_issue", issues, 2 * (t + 1));
      bus(0, dd2_pkg::REG_RDATA, 0);
      chk("rdata", rd, {mem[bk * 8 + pos(s2, 1, b8, il)], mem[bk * 8 + pos(s2, 0, b8, il)]});
      chk("term_on", term_on, od & !self_refresh);
      chk("term_sel", term_sel, rt);
      chk("strobe_diff", strobe_diff, !sd);
      $display("test %0d done", t);
    end
    stop_test();
  end
endmodule
`default_nettype wire
